// ==== rtl/port_params.svh ====
// Purpose: register offsets, field positions, reset values and pin map of the port
// Assumes: byte wide register port with a four bit address
// Notes: included by its bare name, definitions only
`ifndef PORT_PARAMS_SVH
`define PORT_PARAMS_SVH

// ==========================================================
// register offsets
`define OFS_PIN_LEVEL 4'h0
`define OFS_OUT_LATCH 4'h1
`define OFS_DIRECTION 4'h2
`define OFS_SEG_GRP1 4'h3
`define OFS_SEG_GRP2 4'h4
`define OFS_SEG_GRP3 4'h5
`define OFS_SEG_GRP4 4'h6
`define OFS_OPEN_DRAIN 4'h7
`define OFS_PAD_CFG 4'h8

// ==========================================================
// reset values
`define RST_DIRECTION 8'hFF
`define RST_LATCH 8'h00
`define RST_SEG 8'h00
`define RST_OPEN_DRAIN 8'h00
`define RST_PULLUP 1'h0

// ==========================================================
// field positions
`define PAD_PULLUP_BIT 7
`define OD_SERIAL1_BIT 7
`define OD_CAPCOMP2_BIT 6
`define OD_CAPCOMP1_BIT 5
`define OD_SERIAL2_BIT 0
`define OD_IMPL_MASK 8'hE1
`define SEG4_SMALL_MASK 8'h01

// ==========================================================
// segment number of each pin, group1 bit 0 is segment 8
`define SEG_BASE 8
`define SEG_PIN0 24
`define SEG_PIN1 32
`define SEG_PIN2 13
`define SEG_PIN3 17
`define SEG_PIN4 16
`define SEG_PIN5 12
`define SEG_PIN6 27
`define SEG_PIN7 28

`endif

// ==== rtl/port_pkg.sv ====
// Purpose: shared types of the port
// Assumes: nothing
// Notes: constants live in port_params.svh
package port_pkg;
  // one byte of port state
  typedef logic [7:0] port_byte_t;
  // register address
  typedef logic [3:0] reg_addr_t;
endpackage

// ==== rtl/pin_cell.sv ====
// Purpose: drive selection of one port pin
// Assumes: all inputs on the system clock
// Notes: purely combinational, the top registers the results
`timescale 1ns/1ps
module pin_cell (
  // configuration of this pin
  input wire logic dir_in,
  input wire logic latch_bit,
  input wire logic seg_en,
  input wire logic pull_global,
  input wire logic open_drain,
  // peripheral request
  input wire logic own_dir,
  input wire logic periph_oe,
  input wire logic periph_out,
  // drive decision
  output logic drive_out,
  output logic drive_en,
  output logic pull_en
);
  // ==========================================================
  // selection
  // latch drives only with direction clear and no owner or segment
  wire port_drive = !seg_en && !own_dir && !dir_in;
  // peripheral output wins over latch data
  wire periph_drive = !seg_en && periph_oe;
  // open drain only pulls low, releases for a one
  wire periph_en = !open_drain || !periph_out;
  wire periph_level = open_drain ? 1'b0 : periph_out;

  assign drive_en = periph_drive ? periph_en : port_drive;
  assign drive_out = periph_drive ? periph_level : (port_drive & latch_bit);
  // pull-up dies on any output or segment pin
  assign pull_en = pull_global && !seg_en && !periph_drive && !port_drive;
endmodule

// ==== rtl/bidir_port.sv ====
// Purpose: eight bit bidirectional port with peripheral and segment overrides
// Assumes: peripheral request inputs come from logic on clk
// Notes: pin levels pass a two stage synchroniser before use
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "port_params.svh"
module bidir_port #(
  // small package variant, upper segment group mostly absent
  parameter bit SMALL_PKG = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire port_pkg::reg_addr_t reg_addr,
  input wire port_pkg::port_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output port_pkg::port_byte_t reg_rdata,
  // pads
  input wire port_pkg::port_byte_t pin_in,
  output port_pkg::port_byte_t pin_out,
  output port_pkg::port_byte_t pin_oe,
  output port_pkg::port_byte_t pin_pullup,
  output port_pkg::port_byte_t pin_segment,
  // peripheral requests
  input wire port_pkg::port_byte_t periph_own_dir,
  input wire port_pkg::port_byte_t periph_oe,
  input wire port_pkg::port_byte_t periph_out,
  input wire logic capcomp2_route_select,
  // peripheral inputs
  output logic async_receive_input,
  output logic capcomp2_capture_in
);

  // ==========================================================
  // reset release
  logic rst_m_q; // first release stage
  logic rst_s_q; // released reset used everywhere

  // two stage release of the asynchronous reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // ==========================================================
  // pin synchroniser
  port_pkg::port_byte_t pin_m_q; // first stage, read only by second
  port_pkg::port_byte_t pin_s_q; // synchronised pin level

  // two flops before any logic sees the pads
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      pin_m_q <= 8'h00;
      pin_s_q <= 8'h00;
    end else begin
      pin_m_q <= pin_in;
      pin_s_q <= pin_m_q;
    end
  end

  // ==========================================================
  // register decode
  port_pkg::port_byte_t latch_q; // output latch
  port_pkg::port_byte_t dir_q; // direction, 1 = input
  port_pkg::port_byte_t seg1_q; // segments 8..15
  port_pkg::port_byte_t seg2_q; // segments 16..23
  port_pkg::port_byte_t seg3_q; // segments 24..31
  port_pkg::port_byte_t seg4_q; // segments 32..39
  port_pkg::port_byte_t od_q; // open drain control
  logic pad_pu_q; // global pull-up enable

  // write strobes per register
  wire wr_level = reg_wr && (reg_addr == `OFS_PIN_LEVEL);
  wire wr_latch = reg_wr && (reg_addr == `OFS_OUT_LATCH);
  wire wr_dir = reg_wr && (reg_addr == `OFS_DIRECTION);
  wire wr_seg1 = reg_wr && (reg_addr == `OFS_SEG_GRP1);
  wire wr_seg2 = reg_wr && (reg_addr == `OFS_SEG_GRP2);
  wire wr_seg3 = reg_wr && (reg_addr == `OFS_SEG_GRP3);
  wire wr_seg4 = reg_wr && (reg_addr == `OFS_SEG_GRP4);
  wire wr_od = reg_wr && (reg_addr == `OFS_OPEN_DRAIN);
  wire wr_pad = reg_wr && (reg_addr == `OFS_PAD_CFG);

  // latch takes writes through either address
  wire latch_hit = wr_level || wr_latch;
  // upper segment group keeps only bit 0 in the small variant
  wire [7:0] seg4_mask = SMALL_PKG ? `SEG4_SMALL_MASK : 8'hFF;

  // ==========================================================
  // configuration registers
  // latch and direction
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      latch_q <= `RST_LATCH;
      dir_q <= `RST_DIRECTION;
    end else begin
      if (latch_hit) begin
        latch_q <= reg_wdata;
      end
      if (wr_dir) begin
        dir_q <= reg_wdata;
      end
    end
  end

  // segment enables
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      seg1_q <= `RST_SEG;
      seg2_q <= `RST_SEG;
      seg3_q <= `RST_SEG;
      seg4_q <= `RST_SEG;
    end else begin
      if (wr_seg1) begin
        seg1_q <= reg_wdata;
      end
      if (wr_seg2) begin
        seg2_q <= reg_wdata;
      end
      if (wr_seg3) begin
        seg3_q <= reg_wdata;
      end
      if (wr_seg4) begin
        seg4_q <= reg_wdata & seg4_mask;
      end
    end
  end

  // open drain and pad configuration
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      od_q <= `RST_OPEN_DRAIN;
      pad_pu_q <= `RST_PULLUP;
    end else begin
      if (wr_od) begin
        od_q <= reg_wdata & `OD_IMPL_MASK;
      end
      if (wr_pad) begin
        pad_pu_q <= reg_wdata[`PAD_PULLUP_BIT];
      end
    end
  end

  // ==========================================================
  // pin mapping
  // all segment enables, bit 0 is segment 8
  wire [31:0] seg_all = {seg4_q, seg3_q, seg2_q, seg1_q};
  // segment enable of each pin
  wire [7:0] seg_pin = {
    seg_all[`SEG_PIN7 - `SEG_BASE],
    seg_all[`SEG_PIN6 - `SEG_BASE],
    seg_all[`SEG_PIN5 - `SEG_BASE],
    seg_all[`SEG_PIN4 - `SEG_BASE],
    seg_all[`SEG_PIN3 - `SEG_BASE],
    seg_all[`SEG_PIN2 - `SEG_BASE],
    seg_all[`SEG_PIN1 - `SEG_BASE],
    seg_all[`SEG_PIN0 - `SEG_BASE]
  };

  // open drain select per pin: serial1 on 3..5, channels on 1 and 2
  wire [7:0] od_pin = {
    1'b0,
    1'b0,
    od_q[`OD_SERIAL1_BIT],
    od_q[`OD_SERIAL1_BIT],
    od_q[`OD_SERIAL1_BIT],
    od_q[`OD_CAPCOMP1_BIT],
    od_q[`OD_CAPCOMP2_BIT],
    1'b0
  };

  // channel 2 reaches pin 1 only when routed there
  wire [7:0] route_mask = {6'h3F, capcomp2_route_select, 1'b1};
  wire [7:0] own_eff = periph_own_dir & route_mask;
  wire [7:0] poe_eff = periph_oe & route_mask;

  // ==========================================================
  // per pin drive decision
  wire [7:0] drv_out_d; // next pad output level
  wire [7:0] drv_en_d; // next pad output enable
  wire [7:0] pull_d; // next pull-up enable

  // one cell for each of the eight pins
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      pin_cell u_cell (
        .dir_in(dir_q[gi]),
        .latch_bit(latch_q[gi]),
        .seg_en(seg_pin[gi]),
        .pull_global(pad_pu_q),
        .open_drain(od_pin[gi]),
        .own_dir(own_eff[gi]),
        .periph_oe(poe_eff[gi]),
        .periph_out(periph_out[gi]),
        .drive_out(drv_out_d[gi]),
        .drive_en(drv_en_d[gi]),
        .pull_en(pull_d[gi])
      );
    end
  endgenerate

  // ==========================================================
  // peripheral inputs
  // pin 7 feeds the receiver while it is an input pin
  wire rx_d = dir_q[7] && !own_eff[7] && !seg_pin[7] && pin_s_q[7];
  // capture input of channel 2 only from its routed pin
  wire cap_d = capcomp2_route_select && !seg_pin[1] && pin_s_q[1];

  // ==========================================================
  // read mux
  // segment pins read back as zero
  wire [7:0] level_rd = pin_s_q & ~seg_pin;
  wire [7:0] pad_rd = {pad_pu_q, 7'h00};

  // data for the addressed register
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      `OFS_PIN_LEVEL: rd_mux = level_rd;
      `OFS_OUT_LATCH: rd_mux = latch_q;
      `OFS_DIRECTION: rd_mux = dir_q;
      `OFS_SEG_GRP1: rd_mux = seg1_q;
      `OFS_SEG_GRP2: rd_mux = seg2_q;
      `OFS_SEG_GRP3: rd_mux = seg3_q;
      `OFS_SEG_GRP4: rd_mux = seg4_q & seg4_mask;
      `OFS_OPEN_DRAIN: rd_mux = od_q;
      `OFS_PAD_CFG: rd_mux = pad_rd;
      default: rd_mux = 8'h00; // unmapped reads zero
    endcase
  end

  // ==========================================================
  // output registers
  port_pkg::port_byte_t rdata_q; // read answer, one cycle only
  port_pkg::port_byte_t out_q; // pad level
  port_pkg::port_byte_t oe_q; // pad enable
  port_pkg::port_byte_t pu_q; // pull-up
  port_pkg::port_byte_t segsel_q; // segment select
  logic rx_q; // receiver input
  logic cap_q; // capture input

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // pad controls, all from flops
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      out_q <= 8'h00;
      oe_q <= 8'h00;
      pu_q <= 8'h00;
      segsel_q <= 8'h00;
    end else begin
      out_q <= drv_out_d;
      oe_q <= drv_en_d;
      pu_q <= pull_d;
      segsel_q <= seg_pin;
    end
  end

  // peripheral input flops
  always_ff @(posedge clk or negedge rst_s_q) begin
    if (!rst_s_q) begin
      rx_q <= 1'b0;
      cap_q <= 1'b0;
    end else begin
      rx_q <= rx_d;
      cap_q <= cap_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign pin_out = out_q;
  assign pin_oe = oe_q;
  assign pin_pullup = pu_q;
  assign pin_segment = segsel_q;
  assign async_receive_input = rx_q;
  assign capcomp2_capture_in = cap_q;

  // ==========================================================
  // checks
  // all pins inputs right after release
  reset_dir_in_a: assert property (@(posedge clk) disable iff (!rst_s_q)
    $rose(rst_s_q) |-> (dir_q == 8'hFF) && (oe_q == 8'h00))
    else $error("pins not inputs after reset");

  // pull-up off after release
  reset_pull_off_a: assert property (@(posedge clk) disable iff (!rst_s_q)
    $rose(rst_s_q) |-> !pad_pu_q && (pu_q == 8'h00))
    else $error("pull-up enabled after reset");

  // global disable clears every pull-up
  global_pull_off_a: assert property (@(posedge clk) disable iff (!rst_s_q)
    !pad_pu_q |=> (pu_q == 8'h00))
    else $error("pull-up on while globally disabled");

  // no pull-up on a driven pin
  pull_on_out_a: assert property (@(posedge clk) disable iff (!rst_s_q)
    (pu_q & oe_q) == 8'h00)
    else $error("pull-up on an output pin");

  // segment pins never driven digitally
  seg_no_drive_a: assert property (@(posedge clk) disable iff (!rst_s_q)
    (oe_q & segsel_q) == 8'h00)
    else $error("segment pin driven");

  // port write lands in the latch
  port_write_latch_a: assert property (@(posedge clk) disable iff (!rst_s_q)
    wr_level |=> (latch_q == $past(reg_wdata)))
    else $error("port write missed latch");

  // latch drives pin 0 when configured as output
  latch_drive_a: assert property (@(posedge clk) disable iff (!rst_s_q)
    (!dir_q[0] && !seg_pin[0] && !poe_eff[0] && !own_eff[0])
    |=> oe_q[0] && (out_q[0] == $past(latch_q[0])))
    else $error("latch not driving pin 0");

  // open drain never drives pin 3 high
  open_drain_a: assert property (@(posedge clk) disable iff (!rst_s_q)
    (od_pin[3] && poe_eff[3] && !seg_pin[3]) |=> !(oe_q[3] && out_q[3]))
    else $error("open drain pin driven high");

  // serial data output overrides pin 7
  sync_override_a: assert property (@(posedge clk) disable iff (!rst_s_q)
    (poe_eff[7] && !seg_pin[7]) |=> oe_q[7] && (out_q[7] == $past(periph_out[7])))
    else $error("serial data did not override pin 7");

  // pin 7 input reaches the receiver
  rx_feed_a: assert property (@(posedge clk) disable iff (!rst_s_q)
    (dir_q[7] && !own_eff[7] && !seg_pin[7]) |=> (rx_q == $past(pin_s_q[7])))
    else $error("receiver input not fed from pin 7");

  // segment 28 takes pin 7 over
  segment_28_drive_take_a: assert property (@(posedge clk) disable iff (!rst_s_q)
    seg3_q[4] |=> segsel_q[7] && !oe_q[7] && !rx_q)
    else $error("segment 28 did not take pin 7");

  // small variant hides upper segment bits
  seg4_small_a: assert property (@(posedge clk) disable iff (!rst_s_q)
    (SMALL_PKG && reg_rd && (reg_addr == `OFS_SEG_GRP4)) |=> (rdata_q[7:1] == 7'h00))
    else $error("absent segment bits read nonzero");

  // capture input quiet unless routed
  cap_route_a: assert property (@(posedge clk) disable iff (!rst_s_q)
    !capcomp2_route_select |=> !cap_q)
    else $error("capture input active while not routed");
endmodule

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the bidirectional port, one task per scenario
// Assumes: register port with read data one cycle after the read strobe
// Notes: a second instance models the small package variant on the same inputs
`timescale 1ns/1ps
`include "port_params.svh"
module tb;
  // ==========================================================
  // signals
  logic clk; // system clock
  logic rst_n; // async reset, active low
  port_pkg::reg_addr_t reg_addr; // register address
  port_pkg::port_byte_t reg_wdata, reg_rdata, rdata_small; // bus data
  logic reg_wr, reg_rd; // bus strobes
  port_pkg::port_byte_t pin_in, pin_out, pin_oe, pin_pullup, pin_segment; // pads
  port_pkg::port_byte_t periph_own_dir, periph_oe, periph_out; // peripheral requests
  logic capcomp2_route_select, async_receive_input, capcomp2_capture_in; // routing
  int n_mismatch; // mismatches seen
  int checks; // comparisons made

  // ==========================================================
  // devices under test
  bidir_port #(.SMALL_PKG(1'b0)) i_bidir_port (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .pin_segment(pin_segment), .periph_own_dir(periph_own_dir),
    .periph_oe(periph_oe), .periph_out(periph_out),
    .capcomp2_route_select(capcomp2_route_select),
    .async_receive_input(async_receive_input), .capcomp2_capture_in(capcomp2_capture_in));
  // small package variant, only its read data is watched
  bidir_port #(.SMALL_PKG(1'b1)) i_bidir_port_small (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata_small), .pin_in(pin_in), .pin_out(), .pin_oe(), .pin_pullup(),
    .pin_segment(), .periph_own_dir(periph_own_dir), .periph_oe(periph_oe),
    .periph_out(periph_out), .capcomp2_route_select(capcomp2_route_select),
    .async_receive_input(), .capcomp2_capture_in());

  // ==========================================================
  // shared tasks
  // compare one byte and count it
  task automatic chk(input port_pkg::port_byte_t got, input port_pkg::port_byte_t exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write, entered just after an edge
  task automatic wr(input port_pkg::reg_addr_t a, input port_pkg::port_byte_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  // one-cycle read, data taken in the following cycle from both instances
  task automatic rd(input port_pkg::reg_addr_t a, output port_pkg::port_byte_t d,
                    output port_pkg::port_byte_t ds);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    ds = rdata_small;
    @(posedge clk);
  endtask
  // read and compare the main instance
  task automatic rd_chk(input port_pkg::reg_addr_t a, input port_pkg::port_byte_t exp);
    port_pkg::port_byte_t d, ds;
    rd(a, d, ds);
    chk(d, exp);
  endtask
  // let config settle, then compare pad outputs and peripheral inputs
  task automatic outs(input port_pkg::port_byte_t oe, input port_pkg::port_byte_t o,
                      input port_pkg::port_byte_t pu, input port_pkg::port_byte_t sg,
                      input port_pkg::port_byte_t side);
    repeat (3) @(posedge clk);
    #1;
    chk(pin_oe, oe);
    chk(pin_out, o);
    chk(pin_pullup, pu);
    chk(pin_segment, sg);
    chk({6'h00, capcomp2_capture_in, async_receive_input}, side);
    @(posedge clk);
  endtask

  // ==========================================================
  // scenarios
  // reset values of every register, unmapped address reads zero
  task automatic t_reset;
    port_pkg::port_byte_t exp [10];
    exp = '{8'h00, `RST_LATCH, `RST_DIRECTION, `RST_SEG, `RST_SEG, `RST_SEG, `RST_SEG,
            `RST_OPEN_DRAIN, {`RST_PULLUP, 7'h00}, 8'h00};
    for (int i = 0; i < 10; i++) begin
      rd_chk(i[3:0], exp[i]);
    end
    outs(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
  endtask
  // mixed directions, write through the pin level register, pull-ups
  task automatic t_drive;
    wr(`OFS_DIRECTION, 8'h0F);
    wr(`OFS_PIN_LEVEL, 8'hA5);
    pin_in <= 8'h3C;
    outs(8'hF0, 8'hA0, 8'h00, 8'h00, 8'h00);
    rd_chk(`OFS_OUT_LATCH, 8'hA5);
    rd_chk(`OFS_PIN_LEVEL, 8'h3C);
    wr(`OFS_PAD_CFG, 8'hFF);
    rd_chk(`OFS_PAD_CFG, 8'h80);
    outs(8'hF0, 8'hA0, 8'h0F, 8'h00, 8'h00);
    wr(`OFS_PAD_CFG, 8'h00);
    outs(8'hF0, 8'hA0, 8'h00, 8'h00, 8'h00);
  endtask
  // segment 28 on pin 7 takes the pin from latch, pull-up and receiver
  task automatic t_segment;
    wr(`OFS_PAD_CFG, 8'h80);
    pin_in <= 8'hFF;
    wr(`OFS_SEG_GRP3, 8'h10);
    outs(8'h70, 8'h20, 8'h0F, 8'h80, 8'h00);
    rd_chk(`OFS_PIN_LEVEL, 8'h7F);
    wr(`OFS_DIRECTION, 8'hFF);
    outs(8'h00, 8'h00, 8'h7F, 8'h80, 8'h00);
    wr(`OFS_SEG_GRP3, 8'h00);
    outs(8'h00, 8'h00, 8'hFF, 8'h00, 8'h01);
  endtask
  // peripheral override, owned direction and open-drain serial output
  task automatic t_periph;
    wr(`OFS_OUT_LATCH, 8'h00);
    pin_in <= 8'h00;
    periph_own_dir <= 8'h80;
    periph_oe <= 8'h80;
    periph_out <= 8'h80;
    outs(8'h80, 8'h80, 8'h7F, 8'h00, 8'h00);
    periph_own_dir <= 8'h20;
    periph_oe <= 8'h20;
    periph_out <= 8'h20;
    outs(8'h20, 8'h20, 8'hDF, 8'h00, 8'h00);
    wr(`OFS_OPEN_DRAIN, 8'hFF);
    rd_chk(`OFS_OPEN_DRAIN, 8'hE1);
    wr(`OFS_OPEN_DRAIN, 8'h80);
    outs(8'h00, 8'h00, 8'hDF, 8'h00, 8'h00);
    periph_out <= 8'h00;
    outs(8'h20, 8'h00, 8'hDF, 8'h00, 8'h00);
    wr(`OFS_SEG_GRP1, 8'h10);
    outs(8'h00, 8'h00, 8'hDF, 8'h20, 8'h00);
    wr(`OFS_SEG_GRP1, 8'h00);
    wr(`OFS_OPEN_DRAIN, 8'h00);
    periph_own_dir <= 8'h00;
    periph_oe <= 8'h00;
  endtask
  // channel 2 routing to pin 1
  task automatic t_route;
    pin_in <= 8'h02;
    capcomp2_route_select <= 1'b1;
    outs(8'h00, 8'h00, 8'hFF, 8'h00, 8'h02);
    periph_own_dir <= 8'h02;
    periph_oe <= 8'h02;
    periph_out <= 8'h02;
    outs(8'h02, 8'h02, 8'hFD, 8'h00, 8'h02);
    capcomp2_route_select <= 1'b0;
    outs(8'h00, 8'h00, 8'hFF, 8'h00, 8'h00);
    periph_own_dir <= 8'h00;
    periph_oe <= 8'h00;
    periph_out <= 8'h00;
  endtask
  // upper segment group in both variants, unmapped write ignored
  task automatic t_small;
    port_pkg::port_byte_t d, ds;
    wr(`OFS_SEG_GRP4, 8'hFF);
    rd(`OFS_SEG_GRP4, d, ds);
    chk(d, 8'hFF);
    chk(ds, 8'h01);
    wr(`OFS_SEG_GRP4, 8'h00);
    wr(4'h9, 8'hFF);
    rd_chk(4'h9, 8'h00);
  endtask
  // mid-run reset with pull-ups enabled and the latch back at 00, all defaults return
  task automatic t_rerst;
    pin_in <= 8'h00;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
  endtask

  // ==========================================================
  // verdict, the single place where the run ends
  task automatic end_of_test;
    $display("mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog against a hang
  initial begin
    #500000;
    n_mismatch++;
    end_of_test;
  end
  // main sequence
  initial begin
    n_mismatch = 0;
    checks = 0;
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pin_in = 8'h00;
    periph_own_dir = 8'h00;
    periph_oe = 8'h00;
    periph_out = 8'h00;
    capcomp2_route_select = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_drive;
    t_segment;
    t_periph;
    t_route;
    t_small;
    t_rerst;
    end_of_test;
  end
endmodule
